// file: include/bps_pkg.sv
// Package of constants and types for the battery profile select block.
`default_nettype none
package bps_pkg;
   localparam logic [6:0] I2C_ADDR = 7'h55;
   localparam logic [7:0] STATUS_CMD = 8'h6A;
   localparam logic [7:0] STATUS_HI_CMD = 8'h6B;
   localparam logic [7:0] CTRL_CMD = 8'h00;
   localparam logic [7:0] CMD_MAX = 8'h7F;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int LU_BIT = 0;
   localparam int UNSUP_BIT = 1;
   localparam int HIB_BIT = 0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [15:0] PACK0_ID_MV = 16'h006E;
   localparam logic [15:0] PACK1_ID_MV = 16'h042E;
   localparam int CLK_PERIOD_NS = 25;
   localparam int BUS_STUCK_TIMEOUT_NS = 2000000;
   localparam int BUS_STUCK_CYCLES = BUS_STUCK_TIMEOUT_NS / CLK_PERIOD_NS;
   // Profile manager states.
   typedef enum logic [2:0] {
      P_EMPTY = 3'b000,
      P_OCV = 3'b001,
      P_SOC = 3'b010,
      P_LOAD = 3'b011,
      P_CALC = 3'b100,
      P_SEL = 3'b101,
      P_COPY = 3'b110,
      P_GAUGE = 3'b111
   } bps_prof_st_t;
   // Serial engine states.
   typedef enum logic [3:0] {
      I_IDLE = 4'b0000,
      I_ADDR = 4'b0001,
      I_AACK = 4'b0010,
      I_CMD = 4'b0011,
      I_CACK = 4'b0100,
      I_WDAT = 4'b0101,
      I_DACK = 4'b0110,
      I_RDAT = 4'b0111,
      I_RACK = 4'b1000
   } bps_i2c_st_t;
endpackage
`default_nettype wire

// file: verilog/bps_sync2.sv
// Two flip-flop synchroniser for asynchronous inputs.
`default_nettype none
module bps_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage; only the second stage reads it.
   logic [W-1:0] meta_reg;

   // Reset to the idle level so no false edge appears at release.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= INIT;
         q <= INIT;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// file: verilog/bps_top.sv
// Battery profile selection with its serial register port.
`default_nettype none
module bps_top
   import bps_pkg::*;
#(
   parameter int BUS_STUCK_CYC = BUS_STUCK_CYCLES,
   parameter logic [15:0] RA_TOL = 16'h0010,
   parameter int ID_PCT = 10
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic pack_present,
   input wire logic variant_has_id,
   input wire logic default_sel,
   input wire logic meas_done,
   input wire logic [15:0] ocv_mv,
   input wire logic [15:0] load_mv,
   input wire logic [15:0] load_ma,
   input wire logic [15:0] pack_id_sense_mv,
   input wire logic [15:0] dyn_ra0,
   input wire logic [15:0] dyn_ra1,
   input wire logic [15:0] def_ra0,
   input wire logic [15:0] def_ra1,
   input wire logic default_download_done,
   output logic battery_good_out_n,
   output logic meas_req,
   output logic [7:0] soc_out,
   output logic [15:0] impedance_out,
   output logic copy_strobe,
   output logic copy_src,
   output logic copy_dst,
   output logic last_used_profile_bit,
   output logic unknown_pack_flag,
   output logic hibernate_out,
   output logic i2c_sleep_out
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   logic [1:0] line_s; // Synchronised SCL (1) and SDA (0).
   logic pres_s; // Synchronised pack presence.
   bps_sync2 #(.W(2), .INIT(2'h3)) u_line_sync (
      .clk(clk), .reset_n(reset_n), .d({scl_in, sda_in}), .q(line_s));
   bps_sync2 #(.W(1), .INIT(1'h0)) u_pres_sync (
      .clk(clk), .reset_n(reset_n), .d(pack_present), .q(pres_s));

   logic scl_s, sda_s, scl_p_reg, sda_p_reg;
   assign scl_s = line_s[1];
   assign sda_s = line_s[0];
   // Previous line levels give edges and bus conditions.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else begin
         scl_p_reg <= scl_s;
         sda_p_reg <= sda_s;
      end
   end
   wire scl_rise = scl_s && !scl_p_reg;
   wire scl_fall = !scl_s && scl_p_reg;
   wire start_ev = scl_s && scl_p_reg && sda_p_reg && !sda_s;
   wire stop_ev = scl_s && scl_p_reg && !sda_p_reg && sda_s;
   wire line_low = !scl_s || !sda_s;

   ////////////////////////////////////////////////////////////////////////
   // Straps are caught once after reset release and then held.
   logic strap_done_reg, has_id_reg, def_sel_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strap_done_reg <= 1'b0;
         has_id_reg <= 1'b0;
         def_sel_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         has_id_reg <= variant_has_id;
         def_sel_reg <= default_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Matching helpers.
   // Impedance match within the fixed tolerance.
   function automatic logic ra_near(input logic [15:0] a, input logic [15:0] b);
      logic [15:0] d;
      d = (a > b) ? (a - b) : (b - a);
      return d <= RA_TOL;
   endfunction
   // ID voltage inside a percentage window around a level.
   function automatic logic id_near(input logic [15:0] v, input logic [15:0] lvl);
      logic [31:0] d;
      d = (v > lvl) ? 32'(v - lvl) : 32'(lvl - v);
      return (d * 32'd100) <= (32'(lvl) * 32'(ID_PCT));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Profile manager.
   bps_prof_st_t prof_st_reg;
   logic [15:0] ocv_reg, vld_reg, ild_reg, id_reg;
   logic first_done_reg;
   logic [15:0] diff_v;
   assign diff_v = (ocv_reg > vld_reg) ? (ocv_reg - vld_reg) : 16'h0000;
   // Division is guarded so a zero load current gives zero impedance.
   wire [15:0] imped_calc = (ild_reg == 16'h0000) ? 16'h0000 : diff_v / ild_reg;
   wire m_dyn0 = ra_near(impedance_out, dyn_ra0);
   wire m_dyn1 = ra_near(impedance_out, dyn_ra1);
   // Closest default: smaller distance wins, ties go to default 0.
   wire [15:0] dd0 = (impedance_out > def_ra0) ? impedance_out - def_ra0 : def_ra0 - impedance_out;
   wire [15:0] dd1 = (impedance_out > def_ra1) ? impedance_out - def_ra1 : def_ra1 - impedance_out;
   wire close_def = dd1 < dd0;
   wire id0 = id_near(id_reg, PACK0_ID_MV);
   wire id1 = id_near(id_reg, PACK1_ID_MV);
   wire id_n = !id0; // Profile chosen by ID, valid when id0 or id1.
   wire unsup_set = (prof_st_reg == P_SEL) && has_id_reg && !id0 && !id1;
   // The engine is busy during the OCV measurement and while it computes.
   wire i2c_ready = (prof_st_reg != P_OCV) && (prof_st_reg != P_CALC);

   // Sequencing of insertion, measurement and selection.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prof_st_reg <= P_EMPTY;
         battery_good_out_n <= 1'b1;
         meas_req <= 1'b0;
      end else begin
         unique case (prof_st_reg)
            P_EMPTY: begin
               battery_good_out_n <= 1'b1;
               if (pres_s) begin
                  prof_st_reg <= P_OCV;
                  meas_req <= 1'b1;
               end
            end
            P_OCV: if (meas_done) begin
               prof_st_reg <= P_SOC;
               meas_req <= 1'b0;
            end
            P_SOC: begin
               battery_good_out_n <= 1'b0;
               prof_st_reg <= P_LOAD;
               meas_req <= 1'b1;
            end
            P_LOAD: if (meas_done) begin
               prof_st_reg <= P_CALC;
               meas_req <= 1'b0;
            end
            P_CALC: prof_st_reg <= P_SEL;
            P_SEL: prof_st_reg <= first_done_reg ? P_GAUGE : P_COPY;
            P_COPY: prof_st_reg <= P_GAUGE;
            P_GAUGE: if (!pres_s) begin
               prof_st_reg <= P_EMPTY;
               battery_good_out_n <= 1'b1;
            end
         endcase
      end
   end

   // Measured values, state of charge and impedance.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ocv_reg <= 16'h0000;
         vld_reg <= 16'h0000;
         ild_reg <= 16'h0000;
         id_reg <= 16'h0000;
         soc_out <= 8'h00;
         impedance_out <= 16'h0000;
      end else begin
         if (prof_st_reg == P_OCV && meas_done) ocv_reg <= ocv_mv;
         if (prof_st_reg == P_LOAD && meas_done) begin
            vld_reg <= load_mv;
            ild_reg <= load_ma;
            id_reg <= pack_id_sense_mv;
         end
         // The OCV table is held outside; its index is the top OCV byte.
         if (prof_st_reg == P_SOC) soc_out <= ocv_reg[15:8];
         if (prof_st_reg == P_CALC) impedance_out <= imped_calc;
      end
   end

   // Profile choice and copy strobes toward the profile store.
   logic sel_n, copy2_src, copy2_dst;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         first_done_reg <= 1'b0;
         last_used_profile_bit <= 1'b0;
         copy_strobe <= 1'b0;
         copy_src <= 1'b0;
         copy_dst <= 1'b0;
         copy2_src <= 1'b0;
         copy2_dst <= 1'b0;
      end else begin
         copy_strobe <= 1'b0;
         if (prof_st_reg == P_SEL && !first_done_reg) begin
            // First use seeds both dynamic profiles.
            first_done_reg <= 1'b1;
            copy_strobe <= 1'b1;
            copy_dst <= 1'b0;
            copy2_dst <= 1'b1;
            copy_src <= has_id_reg ? 1'b0 : def_sel_reg;
            copy2_src <= has_id_reg ? 1'b1 : def_sel_reg;
            if (has_id_reg && (id0 || id1)) last_used_profile_bit <= id_n;
            if (!has_id_reg) last_used_profile_bit <= 1'b0;
         end else if (prof_st_reg == P_SEL && !has_id_reg) begin
            if (m_dyn0) last_used_profile_bit <= 1'b0;
            else if (m_dyn1) last_used_profile_bit <= 1'b1;
            else begin
               // New pack: the last used dynamic profile is spared.
               copy_strobe <= 1'b1;
               copy_src <= close_def;
               copy_dst <= !last_used_profile_bit;
               last_used_profile_bit <= !last_used_profile_bit;
            end
         end else if (prof_st_reg == P_SEL && (id0 || id1)) begin
            last_used_profile_bit <= id_n;
            if (!(id_n ? m_dyn1 : m_dyn0)) begin
               copy_strobe <= 1'b1;
               copy_src <= id_n;
               copy_dst <= id_n;
            end
         end else if (prof_st_reg == P_COPY) begin
            copy_strobe <= 1'b1;
            copy_src <= copy2_src;
            copy_dst <= copy2_dst;
         end
      end
   end
   assign sel_n = last_used_profile_bit;

   // Unsupported flag: a new mismatch wins over a download clear.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) unknown_pack_flag <= 1'b0;
      else if (unsup_set) unknown_pack_flag <= 1'b1;
      else if (default_download_done) unknown_pack_flag <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus stuck watchdog.
   logic [31:0] stk_cnt_reg;
   logic stuck_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stk_cnt_reg <= 32'h0000_0000;
         stuck_reg <= 1'b0;
         i2c_sleep_out <= 1'b0;
      end else if (!line_low) begin
         stk_cnt_reg <= 32'h0000_0000;
         stuck_reg <= 1'b0;
         i2c_sleep_out <= 1'b0;
      end else if (stuck_reg) begin
         i2c_sleep_out <= 1'b1;
      end else if (stk_cnt_reg >= 32'(BUS_STUCK_CYC - 1)) begin
         stuck_reg <= 1'b1;
      end else begin
         stk_cnt_reg <= stk_cnt_reg + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial slave engine.
   bps_i2c_st_t i2c_st_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] sh_reg, rd_reg, ptr_reg, ctrl_reg;
   logic wr_seen_reg, mack_reg, sda_oe_reg;
   wire [7:0] status_byte = {6'h00, unknown_pack_flag, sel_n};
   wire byte_end = scl_fall && (bit_cnt_reg == BYTE_BITS);
   wire addr_hit = sh_reg[7:1] == I2C_ADDR;
   wire wr_ok = (ptr_reg == CTRL_CMD) && !wr_seen_reg;
   wire [7:0] ptr_inc = ptr_reg + 8'h01;
   // Read data by location; unmapped locations read zero.
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] st,
         input logic [7:0] ct);
      if (a == STATUS_CMD) return st;
      if (a == CTRL_CMD) return ct;
      return 8'h00;
   endfunction
   // Bytes at the pointer and at the next location; the register values are
   // passed in so that every source is visible to the continuous assignment.
   wire [7:0] rd_cur = rd_byte(ptr_reg, status_byte, ctrl_reg);
   wire [7:0] rd_nxt = rd_byte(ptr_inc, status_byte, ctrl_reg);

   // Shift in on SCL rise; act and drive on SCL fall.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         i2c_st_reg <= I_IDLE;
         bit_cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         rd_reg <= 8'h00;
         ptr_reg <= 8'h00;
         wr_seen_reg <= 1'b0;
         mack_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
      end else if (stuck_reg) begin
         i2c_st_reg <= I_IDLE;
         sda_oe_reg <= 1'b0;
      end else if (start_ev || stop_ev) begin
         i2c_st_reg <= start_ev ? I_ADDR : I_IDLE;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
         // Acknowledge clocks do not shift, so the direction bit survives.
         if (i2c_st_reg == I_RACK) mack_reg <= sda_s;
         else if (i2c_st_reg inside {I_ADDR, I_CMD, I_WDAT}) begin
            sh_reg <= {sh_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end else if (scl_fall) begin
         unique case (i2c_st_reg)
            I_IDLE: sda_oe_reg <= 1'b0;
            I_ADDR: if (byte_end) begin
               // Own address and ready: acknowledge, else go silent.
               sda_oe_reg <= addr_hit && i2c_ready;
               i2c_st_reg <= (addr_hit && i2c_ready) ? I_AACK : I_IDLE;
            end
            I_AACK: begin
               bit_cnt_reg <= 4'h0;
               if (sh_reg[0]) begin
                  // Read with no command byte reads at the pointer.
                  rd_reg <= {rd_cur[6:0], 1'b0};
                  sda_oe_reg <= !rd_cur[7];
                  bit_cnt_reg <= 4'h1;
                  i2c_st_reg <= I_RDAT;
               end else begin
                  sda_oe_reg <= 1'b0;
                  i2c_st_reg <= I_CMD;
               end
            end
            I_CMD: if (byte_end) begin
               sda_oe_reg <= (sh_reg <= CMD_MAX);
               ptr_reg <= sh_reg;
               i2c_st_reg <= (sh_reg <= CMD_MAX) ? I_CACK : I_IDLE;
            end
            I_CACK: begin
               sda_oe_reg <= 1'b0;
               bit_cnt_reg <= 4'h0;
               wr_seen_reg <= 1'b0;
               i2c_st_reg <= I_WDAT;
            end
            I_WDAT: if (byte_end) begin
               // Only the first byte to a writable location is taken.
               sda_oe_reg <= wr_ok;
               wr_seen_reg <= 1'b1;
               if (wr_ok) ptr_reg <= ptr_inc;
               i2c_st_reg <= I_DACK;
            end
            I_DACK: begin
               sda_oe_reg <= 1'b0;
               bit_cnt_reg <= 4'h0;
               i2c_st_reg <= I_WDAT;
            end
            I_RDAT: if (bit_cnt_reg == BYTE_BITS) begin
               sda_oe_reg <= 1'b0;
               i2c_st_reg <= I_RACK;
            end else begin
               sda_oe_reg <= !rd_reg[7];
               rd_reg <= {rd_reg[6:0], 1'b0};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            I_RACK: if (!mack_reg) begin
               // Master acknowledged: step on and send the next byte.
               ptr_reg <= ptr_inc;
               rd_reg <= {rd_nxt[6:0], 1'b0};
               sda_oe_reg <= !rd_nxt[7];
               bit_cnt_reg <= 4'h1;
               i2c_st_reg <= I_RDAT;
            end else begin
               sda_oe_reg <= 1'b0;
               i2c_st_reg <= I_IDLE;
            end
            default: i2c_st_reg <= I_IDLE;
         endcase
      end
   end

   // Control byte write and hibernate; only own address wakes.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= CTRL_RST;
         hibernate_out <= 1'b0;
      end else begin
         if (scl_fall && i2c_st_reg == I_WDAT && byte_end && wr_ok) begin
            ctrl_reg <= sh_reg;
            hibernate_out <= sh_reg[HIB_BIT];
         end else if (scl_fall && i2c_st_reg == I_ADDR && byte_end && addr_hit) begin
            hibernate_out <= 1'b0;
         end
      end
   end

   // Open-drain pins only ever pull low; SCL is never stretched.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= sda_oe_reg && !stuck_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence addr_end_s;
      scl_fall && i2c_st_reg == I_ADDR && bit_cnt_reg == BYTE_BITS;
   endsequence
   chk_bgood_after_ocv: assert property (
      (prof_st_reg == P_OCV && meas_done) |-> ##3 !battery_good_out_n)
      else $error("battery good not asserted after OCV");
   chk_bgood_off_ocv: assert property (
      prof_st_reg == P_OCV |-> battery_good_out_n)
      else $error("battery good active before OCV");
   chk_foreign_addr: assert property (
      (addr_end_s and !addr_hit) |=> !sda_oe_reg && i2c_st_reg == I_IDLE)
      else $error("foreign address acknowledged");
   chk_cmd_range: assert property (
      (scl_fall && i2c_st_reg == I_CMD && byte_end && sh_reg > CMD_MAX) |=> !sda_oe_reg)
      else $error("command above range acknowledged");
   chk_ro_write: assert property (
      (scl_fall && i2c_st_reg == I_WDAT && byte_end && ptr_reg == STATUS_CMD)
      |=> !sda_oe_reg ##1 !sda_oe)
      else $error("read-only write acknowledged");
   chk_ptr_step: assert property (
      (scl_fall && i2c_st_reg == I_RACK && !mack_reg && !stuck_reg)
      |=> ptr_reg == $past(ptr_inc))
      else $error("pointer did not step on ack");
   chk_stuck_release: assert property (
      $rose(stuck_reg) |=> !sda_oe [*2])
      else $error("lines not released on bus error");
   chk_stuck_sleep: assert property (
      (stuck_reg && line_low) |=> i2c_sleep_out)
      else $error("engine not asleep on held bus");
   chk_unsup_set: assert property (
      unsup_set |=> unknown_pack_flag)
      else $error("unsupported flag not set");
   chk_unsup_clear: assert property (
      (default_download_done && !unsup_set && prof_st_reg != P_SEL) |=> !unknown_pack_flag)
      else $error("unsupported flag not cleared");
   chk_hib_foreign: assert property (
      ((hibernate_out && !addr_hit) and addr_end_s) |=> hibernate_out)
      else $error("hibernate left on foreign address");
endmodule
`default_nettype wire

// file: sim/bps_host_model.sv
// Behavioural serial bus master standing in for the system controller.
`default_nettype none
module bps_host_model (
   input wire logic sda_line,
   output var logic scl_low,
   output var logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // Both lines start released, so the pull-ups hold them high.
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Start: data falls while the clock is high; it also serves as a repeated start.
   task automatic start();
      #100 sda_low = 1'b0;
      #100 scl_low = 1'b0;
      #200 sda_low = 1'b1;
      #200 scl_low = 1'b1;
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      #100 sda_low = 1'b1;
      #100 scl_low = 1'b0;
      #200 sda_low = 1'b0;
      #200;
   endtask
   // Data moves mid-low, away from the synchronised clock edges, and is read late in high.
   task automatic bit_io(input logic b, output logic r);
      #100 sda_low = !b;
      #100 scl_low = 1'b0;
      #200 r = sda_line;
      scl_low = 1'b1;
   endtask
   // Eight bits out or in, then the acknowledge bit.
   task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(nak, a);
   endtask
endmodule
`default_nettype wire

// file: sim/bps_top_tb.sv
// Self-checking bench for the profile selector and its serial port.
`default_nettype none
module bps_top_tb import bps_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic pack_present = 1'b0, meas_done = 1'b0, default_download_done = 1'b0;
   logic [15:0] ocv_mv = '0, load_mv = '0, load_ma = '0, pack_id_sense_mv = '0;
   logic [15:0] dyn_ra0 = '0, dyn_ra1 = '0, impedance_out;
   logic [15:0] rnd = 16'hE475;
   logic scl_out, scl_oe, sda_out, sda_oe, battery_good_out_n, meas_req, copy_strobe, a;
   logic copy_src, copy_dst, last_used_profile_bit, unknown_pack_flag, hibernate_out;
   logic i2c_sleep_out, h_scl, h_sda, has_id = 1'b1;
   logic [7:0] soc_out, r;
   int failures = 0;
   int samples_checked = 0;
   // Open-drain lines with pull-ups: low whenever any party pulls.
   wire logic scl_in = !(h_scl | scl_oe);
   wire logic sda_in = !(h_sda | sda_oe);
   always #12.5 clk = ~clk;
   bps_host_model u_host (.sda_line(sda_in), .scl_low(h_scl), .sda_low(h_sda));
   bps_top #(.BUS_STUCK_CYC(1000)) u_dut (.clk, .reset_n, .scl_in, .scl_out, .scl_oe, .sda_in,
      .sda_out, .sda_oe, .pack_present, .variant_has_id(has_id), .default_sel(1'b0), .meas_done,
      .ocv_mv, .load_mv, .load_ma, .pack_id_sense_mv, .dyn_ra0, .dyn_ra1, .def_ra0(16'h0100),
      .def_ra1(16'h0300), .default_download_done, .battery_good_out_n, .meas_req, .soc_out,
      .impedance_out, .copy_strobe, .copy_src, .copy_dst, .last_used_profile_bit,
      .unknown_pack_flag, .hibernate_out, .i2c_sleep_out);
   ////////////////////////////////////////////////////////////////////////////////////////
   // Sixteen-bit xorshift step for repeatable stimulus.
   function automatic logic [15:0] xs(input logic [15:0] x);
      logic [15:0] y;
      y = x ^ (x << 7);
      y = y ^ (y >> 9);
      return y ^ (y << 8);
   endfunction
   // Expected impedance; a zero current or no voltage drop gives zero.
   function automatic logic [15:0] imp_exp(input logic [15:0] o, v, i);
      return (i == 16'h0 || o <= v) ? 16'h0 : (o - v) / i;
   endfunction
   task automatic finish_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for a measurement request; ends just after a clock edge.
   task automatic wait_req();
      int n;
      n = 0;
      while (meas_req !== 1'b1) begin
         @(posedge clk) #2 n++;
         if (n > 50) begin
            failures++;
            finish_test();
         end
      end
   endtask
   task automatic pulse();
      meas_done = 1'b1;
      @(posedge clk) #2 meas_done = 1'b0;
   endtask
   // One pack insertion: open-circuit reading, then loaded reading with the ID voltage.
   task automatic insert(input logic [15:0] id, input int strobes, input logic unk,
         input logic lu);
      int n;
      rnd = xs(rnd);
      @(posedge clk) #2 pack_present = 1'b1;
      {dyn_ra0, dyn_ra1} = {rnd, ~rnd};
      wait_req();
      chk(battery_good_out_n, 1'b1);
      ocv_mv = 16'h0E00 | (rnd & 16'h03FF);
      pulse();
      repeat (3) @(posedge clk);
      #2 chk(battery_good_out_n, 1'b0);
      chk(soc_out, ocv_mv[15:8]);
      wait_req();
      load_mv = ocv_mv - (rnd & 16'h00FF);
      load_ma = 16'h1 + (rnd >> 13);
      pack_id_sense_mv = id;
      pulse();
      n = 0;
      repeat (8) begin
         @(posedge clk) #1;
         if (copy_strobe === 1'b1) begin
            n++;
            chk(copy_src, copy_dst & has_id);
         end
      end
      chk(impedance_out, imp_exp(ocv_mv, load_mv, load_ma));
      chk(n, strobes);
      chk(unknown_pack_flag, unk);
      chk(last_used_profile_bit, lu);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk);
      #2 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      insert(PACK0_ID_MV, 2, 1'b0, 1'b0);
      @(posedge clk) #2 pack_present = 1'b0;
      repeat (6) @(posedge clk);
      insert(16'h01F4, 0, 1'b1, 1'b0);
      $display("test insertion done");
      u_host.start();
      u_host.xfer(8'hA8, 1'b1, r, a);
      chk(a, 1'b1);
      u_host.start();
      u_host.xfer(8'hAA, 1'b1, r, a);
      chk(a, 1'b0);
      u_host.xfer(STATUS_CMD, 1'b1, r, a);
      u_host.xfer(8'h55, 1'b1, r, a);
      chk(a, 1'b1);
      u_host.start();
      u_host.xfer(8'hAB, 1'b1, r, a);
      u_host.xfer(8'hFF, 1'b0, r, a);
      chk(r, {6'h0, 1'b1, 1'b0});
      u_host.xfer(8'hFF, 1'b1, r, a);
      chk(r, 8'h00);
      u_host.start();
      u_host.xfer(8'hAA, 1'b1, r, a);
      u_host.xfer(8'h80, 1'b1, r, a);
      chk(a, 1'b1);
      u_host.start();
      u_host.xfer(8'hAA, 1'b1, r, a);
      u_host.xfer(CTRL_CMD, 1'b1, r, a);
      u_host.xfer(8'h01, 1'b1, r, a);
      chk(a, 1'b0);
      u_host.xfer(8'h00, 1'b1, r, a);
      chk(a, 1'b1);
      u_host.stop();
      chk(hibernate_out, 1'b1);
      u_host.start();
      u_host.xfer(8'hA8, 1'b1, r, a);
      chk(hibernate_out, 1'b1);
      u_host.start();
      u_host.xfer(8'hAA, 1'b1, r, a);
      u_host.stop();
      chk(hibernate_out, 1'b0);
      @(posedge clk) #2 default_download_done = 1'b1;
      @(posedge clk) #2 default_download_done = 1'b0;
      repeat (2) @(posedge clk);
      #2 chk(unknown_pack_flag, 1'b0);
      @(posedge clk) #2 pack_present = 1'b0;
      repeat (6) @(posedge clk);
      insert(PACK1_ID_MV, 1, 1'b0, 1'b1);
      $display("test serial port done");
      u_host.scl_low = 1'b1;
      repeat (1010) @(posedge clk);
      #2 chk(i2c_sleep_out, 1'b1);
      chk(sda_oe, 1'b0);
      chk({scl_oe, scl_out, sda_out}, 3'h0);
      u_host.scl_low = 1'b0;
      repeat (5) @(posedge clk);
      #2 chk(i2c_sleep_out, 1'b0);
      $display("test stuck bus done");
      pack_present = 1'b0;
      has_id = 1'b0;
      reset_n = 1'b0;
      repeat (12) @(posedge clk);
      #2 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      insert(PACK0_ID_MV, 2, 1'b0, 1'b0);
      @(posedge clk) #2 pack_present = 1'b0;
      repeat (6) @(posedge clk);
      insert(PACK0_ID_MV, 1, 1'b0, 1'b1);
      $display("test simple variant done");
      finish_test();
   end
endmodule
`default_nettype wire
